// File: uvt_pkg.sv
/*
  Shared constants, types and register map of the undervoltage trip block.
  Assumes one 40 MHz clock and voltage magnitudes scaled so that
  NOMINAL equals 100 % of the rated voltage.
*/
package uvt_pkg;

  localparam int NUM_PH  = 3;
  localparam int VOLT_W  = 16;
  localparam int PCT_W   = 8;
  localparam int DELAY_W = 16;
  localparam int LVL_W   = 32;
  localparam int ADR_W   = 8;
  localparam int DAT_W   = 32;
  localparam int SEL_W   = 4;
  localparam int CNT_W   = 16;

  // clock rate and the millisecond tick derived from it
  localparam int CLK_HZ      = 40_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;

  // magnitude that stands for 100 % (arbitrary scaling choice)
  localparam logic [VOLT_W-1:0] NOMINAL     = 16'h2710;
  localparam logic [LVL_W-1:0]  PCT_SCALE   = 32'h0000_0064;
  localparam logic [LVL_W-1:0]  RATIO_SCALE = 32'h0000_2710;
  localparam logic [PCT_W-1:0]  RATIO_BASE  = 8'h64;

  // setting ranges and defaults
  localparam logic [PCT_W-1:0]   START_MIN = 8'h1E;
  localparam logic [PCT_W-1:0]   START_MAX = 8'h82;
  localparam logic [PCT_W-1:0]   START_DEF = 8'h5A;
  localparam logic [PCT_W-1:0]   BLOCK_MIN = 8'h00;
  localparam logic [PCT_W-1:0]   BLOCK_MAX = 8'h14;
  localparam logic [PCT_W-1:0]   BLOCK_DEF = 8'h0A;
  localparam logic [PCT_W-1:0]   HYST_MIN  = 8'h01;
  localparam logic [PCT_W-1:0]   HYST_MAX  = 8'h0A;
  localparam logic [PCT_W-1:0]   HYST_DEF  = 8'h05;
  localparam logic [DELAY_W-1:0] DELAY_MIN = 16'h0032;
  localparam logic [DELAY_W-1:0] DELAY_MAX = 16'hEA60;
  localparam logic [DELAY_W-1:0] DELAY_DEF = 16'h0064;

  // register byte offsets
  localparam logic [ADR_W-1:0] ADR_CTRL  = 8'h00;
  localparam logic [ADR_W-1:0] ADR_START = 8'h04;
  localparam logic [ADR_W-1:0] ADR_BLOCK = 8'h08;
  localparam logic [ADR_W-1:0] ADR_HYST  = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_DELAY = 8'h10;
  localparam logic [ADR_W-1:0] ADR_STAT  = 8'h14;
  localparam logic [ADR_W-1:0] ADR_IRQ   = 8'h18;
  localparam logic [ADR_W-1:0] ADR_MASK  = 8'h1C;
  localparam logic [ADR_W-1:0] ADR_V1    = 8'h20;
  localparam logic [ADR_W-1:0] ADR_V2    = 8'h24;
  localparam logic [ADR_W-1:0] ADR_V3    = 8'h28;
  localparam logic [ADR_W-1:0] ADR_TRCNT = 8'h2C;

  // field positions
  localparam int CTRL_OPER_LSB = 0;
  localparam int CTRL_ONLY_BIT = 2;
  localparam int ST_GEN_START  = 3;
  localparam int ST_GEN_TRIP   = 4;
  localparam int ST_BLOCKED    = 5;
  localparam int IRQ_W         = 2;
  localparam int IRQ_START     = 0;
  localparam int IRQ_TRIP      = 1;

  typedef enum logic [1:0] {
    OP_OFF = 2'b00,
    OP_ONE = 2'b01,
    OP_TWO = 2'b10,
    OP_ALL = 2'b11
  } uvt_oper_e;

  typedef enum logic [1:0] {
    PH_IDLE    = 2'b00,
    PH_STARTED = 2'b01,
    PH_TRIPPED = 2'b10
  } uvt_phase_e;

  localparam logic [1:0] TRIPS_ONE = 2'h1;
  localparam logic [1:0] TRIPS_TWO = 2'h2;
  localparam logic [1:0] TRIPS_ALL = 2'h3;

  typedef struct packed {
    uvt_oper_e          oper;
    logic               startOnly;
    logic [PCT_W-1:0]   startPct;
    logic [PCT_W-1:0]   blockPct;
    logic [PCT_W-1:0]   hystPct;
    logic [DELAY_W-1:0] delayMs;
  } uvt_cfg_s;

  typedef struct packed {
    logic [LVL_W-1:0] startLvl;
    logic [LVL_W-1:0] blockLvl;
    logic [LVL_W-1:0] resetLvl;
  } uvt_levels_s;

endpackage : uvt_pkg

// File: uvt_ms_tick.sv
/*
  Millisecond tick generator: one-cycle pulse every CYCLES clocks.
  Assumes the shared synchronous active-high reset.
*/
module uvt_ms_tick #(
  parameter int CYCLES = uvt_pkg::TICK_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  output logic      tick
);

  logic [31:0] count;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (count == 32'(CYCLES - 1)) begin
      count <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end

endmodule : uvt_ms_tick

// File: uvt_phase.sv
/*
  One phase of the undervoltage characteristic: threshold compare with
  hysteresis, block-level suppression and definite-time counting.
  Assumes the voltage comes from logic on the same clock.
*/
module uvt_phase (
  input  wire logic                           ref_clk,
  input  wire logic                           reset,
  input  wire logic                           enable,
  input  wire logic                           tick,
  input  wire logic [uvt_pkg::VOLT_W-1:0]     voltage,
  input  wire uvt_pkg::uvt_levels_s           levels,
  input  wire logic [uvt_pkg::DELAY_W-1:0]    delayMs,
  output logic                                start,
  output logic                                tripInternal
);

  uvt_pkg::uvt_phase_e state;
  logic [uvt_pkg::LVL_W-1:0]   vPct;
  logic [uvt_pkg::LVL_W-1:0]   vRatio;
  logic [uvt_pkg::DELAY_W-1:0] elapsed;
  logic belowStart;
  logic belowBlock;
  logic aboveReset;

  assign vPct       = uvt_pkg::LVL_W'(voltage) * uvt_pkg::PCT_SCALE;
  assign vRatio     = uvt_pkg::LVL_W'(voltage) * uvt_pkg::RATIO_SCALE;
  assign belowStart = vPct < levels.startLvl;
  assign belowBlock = vPct < levels.blockLvl;
  assign aboveReset = vRatio > levels.resetLvl;

  always_ff @(posedge ref_clk) begin
    if (reset || !enable || belowBlock) begin
      state <= uvt_pkg::PH_IDLE;
    end else begin
      case (state)
        uvt_pkg::PH_IDLE: begin
          if (belowStart) begin
            state <= uvt_pkg::PH_STARTED;
          end
        end
        uvt_pkg::PH_STARTED, uvt_pkg::PH_TRIPPED: begin
          if (aboveReset) begin
            state <= uvt_pkg::PH_IDLE;
          end else if (elapsed >= delayMs) begin
            state <= uvt_pkg::PH_TRIPPED;
          end
        end
        default: state <= uvt_pkg::PH_IDLE;
      endcase
    end
  end

  // the delay holds, not restarts, inside the hysteresis band
  always_ff @(posedge ref_clk) begin
    if (reset || state == uvt_pkg::PH_IDLE) begin
      elapsed <= '0;
    end else if (tick && belowStart && elapsed < delayMs) begin
      elapsed <= elapsed + uvt_pkg::DELAY_W'(1);
    end
  end

  assign start        = state != uvt_pkg::PH_IDLE;
  assign tripInternal = state == uvt_pkg::PH_TRIPPED;

endmodule : uvt_phase

// File: uvt_undervoltage_function.sv
/*
  Three-phase definite-time undervoltage protection with a Wishbone
  classic register slave and a masked interrupt.
  Assumes phase magnitudes (or phase-to-phase magnitudes) and the block
  input are driven by logic on ref_clk.
*/
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
// Function
// - phase starts while below start threshold
// - start suppressed below block threshold
// - delay setting 50 to 60000 ms
// - delay counts only while below start
// - phase trip when count reaches delay
// - operation selects off or phase voting
// - start-only setting suppresses general trip
// - three per-phase start outputs
// - per-phase trips stay internal
// - one general start output
// - one general trip output
// - block input forces all start and trip outputs inactive
// - general start on any started phase
module uvt_undervoltage_function #(
  parameter int TICK_CYCLES = uvt_pkg::TICK_CYCLES
) (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [uvt_pkg::ADR_W-1:0]     adr_i,
  input  wire logic [uvt_pkg::SEL_W-1:0]     sel_i,
  input  wire logic [uvt_pkg::DAT_W-1:0]     dat_i,
  output logic      [uvt_pkg::DAT_W-1:0]     dat_o,
  output logic                               ack_o,
  input  wire logic [uvt_pkg::VOLT_W-1:0]    phase1Fundamental,
  input  wire logic [uvt_pkg::VOLT_W-1:0]    phase2Fundamental,
  input  wire logic [uvt_pkg::VOLT_W-1:0]    phase3Fundamental,
  input  wire logic                          functionBlockInput,
  output logic                               phase1Start,
  output logic                               phase2Start,
  output logic                               phase3Start,
  output logic                               generalStart,
  output logic                               generalTrip,
  output logic                               irq
);

  uvt_pkg::uvt_cfg_s    cfg;
  uvt_pkg::uvt_levels_s levels;
  uvt_pkg::uvt_levels_s next_levels;

  uvt_pkg::uvt_oper_e          oper;
  logic                        startOnly;
  logic [uvt_pkg::PCT_W-1:0]   startPct;
  logic [uvt_pkg::PCT_W-1:0]   blockPct;
  logic [uvt_pkg::PCT_W-1:0]   hystPct;
  logic [uvt_pkg::DELAY_W-1:0] delayMs;

  logic [uvt_pkg::VOLT_W-1:0]  volt [uvt_pkg::NUM_PH];
  logic [uvt_pkg::NUM_PH-1:0]  phStart;
  logic [uvt_pkg::NUM_PH-1:0]  phaseTripInternal;
  logic [uvt_pkg::NUM_PH-1:0]  startOut;
  logic [1:0]                  tripCount;
  logic                        tick;
  logic                        enable;
  logic                        votePass;
  logic                        next_generalTrip;
  logic                        prevStart;
  logic                        prevTrip;
  logic [uvt_pkg::IRQ_W-1:0]   irqStatus;
  logic [uvt_pkg::IRQ_W-1:0]   irqMask;
  logic [uvt_pkg::IRQ_W-1:0]   irqEvent;
  logic [uvt_pkg::CNT_W-1:0]   tripEvents;
  logic [uvt_pkg::DAT_W-1:0]   byteMask;
  logic [uvt_pkg::DAT_W-1:0]   wrWord;
  logic [uvt_pkg::DAT_W-1:0]   next_dat;
  logic                        access;
  logic                        wrStrobe;

  // the block input and the operation setting both gate every phase
  assign enable = !functionBlockInput
                  && cfg.oper != uvt_pkg::OP_OFF;

  // one driver for the settings word; field order follows the struct
  assign cfg = {oper, startOnly, startPct, blockPct, hystPct, delayMs};

  // the measurement stage chooses phase or phase-to-phase values
  assign volt[0] = phase1Fundamental;
  assign volt[1] = phase2Fundamental;
  assign volt[2] = phase3Fundamental;

  uvt_ms_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .ref_clk (ref_clk),
    .reset   (reset),
    .tick    (tick)
  );

  // levels are registered so the wide products stay off the compare path
  always_comb begin
    next_levels.startLvl = uvt_pkg::LVL_W'(cfg.startPct)
                           * uvt_pkg::LVL_W'(uvt_pkg::NOMINAL);
    next_levels.blockLvl = uvt_pkg::LVL_W'(cfg.blockPct)
                           * uvt_pkg::LVL_W'(uvt_pkg::NOMINAL);
    next_levels.resetLvl = next_levels.startLvl
                           * uvt_pkg::LVL_W'(uvt_pkg::RATIO_BASE
                                             + cfg.hystPct);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      levels <= '0;
    end else begin
      levels <= next_levels;
    end
  end

  for (genvar p = 0; p < uvt_pkg::NUM_PH; p++) begin : g_phase
    uvt_phase u_phase (
      .ref_clk      (ref_clk),
      .reset        (reset),
      .enable       (enable),
      .tick         (tick),
      .voltage      (volt[p]),
      .levels       (levels),
      .delayMs      (cfg.delayMs),
      .start        (phStart[p]),
      .tripInternal (phaseTripInternal[p])
    );
  end

  // decision logic
  always_comb begin
    tripCount = 2'h0;
    for (int p = 0; p < uvt_pkg::NUM_PH; p++) begin
      tripCount = tripCount + 2'(phaseTripInternal[p]);
    end
  end

  always_comb begin
    case (cfg.oper)
      uvt_pkg::OP_ONE: votePass = tripCount >= uvt_pkg::TRIPS_ONE;
      uvt_pkg::OP_TWO: votePass = tripCount >= uvt_pkg::TRIPS_TWO;
      uvt_pkg::OP_ALL: votePass = tripCount == uvt_pkg::TRIPS_ALL;
      default:         votePass = 1'b0;
    endcase
  end

  assign next_generalTrip = enable && votePass
                            && !cfg.startOnly;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      startOut     <= '0;
      generalStart <= 1'b0;
      generalTrip  <= 1'b0;
    end else begin
      startOut     <= enable ? phStart : '0;
      generalStart <= enable && (|phStart);
      generalTrip  <= next_generalTrip;
    end
  end

  assign phase1Start = startOut[0];
  assign phase2Start = startOut[1];
  assign phase3Start = startOut[2];

  // interrupt events are rising edges of the general outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prevStart <= 1'b0;
      prevTrip  <= 1'b0;
    end else begin
      prevStart <= generalStart;
      prevTrip  <= generalTrip;
    end
  end

  always_comb begin
    irqEvent                     = '0;
    irqEvent[uvt_pkg::IRQ_START] = generalStart && !prevStart;
    irqEvent[uvt_pkg::IRQ_TRIP]  = generalTrip && !prevTrip;
  end

  // wishbone classic slave: ack one cycle after the request is seen
  assign access   = cyc_i && stb_i && !ack_o;
  assign wrStrobe = access && we_i;

  always_comb begin
    for (int b = 0; b < uvt_pkg::SEL_W; b++) begin
      byteMask[b*8 +: 8] = {8{sel_i[b]}};
    end
  end

  assign wrWord = dat_i & byteMask;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  function automatic logic [uvt_pkg::PCT_W-1:0] clampPct(
    input logic [uvt_pkg::DAT_W-1:0] val,
    input logic [uvt_pkg::PCT_W-1:0] lo,
    input logic [uvt_pkg::PCT_W-1:0] hi
  );
    if (val < uvt_pkg::DAT_W'(lo)) begin
      return lo;
    end else if (val > uvt_pkg::DAT_W'(hi)) begin
      return hi;
    end
    return val[uvt_pkg::PCT_W-1:0];
  endfunction : clampPct

  // out-of-range writes saturate so the setting never leaves its range
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      oper      <= uvt_pkg::OP_OFF;
      startOnly <= 1'b0;
    end else if (wrStrobe && adr_i == uvt_pkg::ADR_CTRL && sel_i[0]) begin
      oper      <= uvt_pkg::uvt_oper_e'(
                     dat_i[uvt_pkg::CTRL_OPER_LSB +: 2]);
      startOnly <= dat_i[uvt_pkg::CTRL_ONLY_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      startPct <= uvt_pkg::START_DEF;
    end else if (wrStrobe && adr_i == uvt_pkg::ADR_START) begin
      startPct <= clampPct(wrWord, uvt_pkg::START_MIN,
                           uvt_pkg::START_MAX);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      blockPct <= uvt_pkg::BLOCK_DEF;
    end else if (wrStrobe && adr_i == uvt_pkg::ADR_BLOCK) begin
      blockPct <= clampPct(wrWord, uvt_pkg::BLOCK_MIN,
                           uvt_pkg::BLOCK_MAX);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hystPct <= uvt_pkg::HYST_DEF;
    end else if (wrStrobe && adr_i == uvt_pkg::ADR_HYST) begin
      hystPct <= clampPct(wrWord, uvt_pkg::HYST_MIN,
                          uvt_pkg::HYST_MAX);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      delayMs <= uvt_pkg::DELAY_DEF;
    end else if (wrStrobe && adr_i == uvt_pkg::ADR_DELAY) begin
      if (wrWord < uvt_pkg::DAT_W'(uvt_pkg::DELAY_MIN)) begin
        delayMs <= uvt_pkg::DELAY_MIN;
      end else if (wrWord > uvt_pkg::DAT_W'(uvt_pkg::DELAY_MAX)) begin
        delayMs <= uvt_pkg::DELAY_MAX;
      end else begin
        delayMs <= wrWord[uvt_pkg::DELAY_W-1:0];
      end
    end
  end

  // a new event in the clearing cycle keeps its bit set
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irqStatus <= '0;
    end else if (wrStrobe && adr_i == uvt_pkg::ADR_IRQ && sel_i[0]) begin
      irqStatus <= (irqStatus & ~dat_i[uvt_pkg::IRQ_W-1:0]) | irqEvent;
    end else begin
      irqStatus <= irqStatus | irqEvent;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irqMask <= '0;
    end else if (wrStrobe && adr_i == uvt_pkg::ADR_MASK && sel_i[0]) begin
      irqMask <= dat_i[uvt_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // saturating count of general trips; a write clears it unless a trip event comes in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tripEvents <= '0;
    end else if (irqEvent[uvt_pkg::IRQ_TRIP]) begin
      if (tripEvents != '1) begin
        tripEvents <= tripEvents + uvt_pkg::CNT_W'(1);
      end
    end else if (wrStrobe && adr_i == uvt_pkg::ADR_TRCNT) begin
      tripEvents <= '0;
    end
  end

  always_comb begin
    next_dat = '0;
    case (adr_i)
      uvt_pkg::ADR_CTRL: begin
        next_dat[uvt_pkg::CTRL_OPER_LSB +: 2] = cfg.oper;
        next_dat[uvt_pkg::CTRL_ONLY_BIT]      = cfg.startOnly;
      end
      uvt_pkg::ADR_START: next_dat[uvt_pkg::PCT_W-1:0] = cfg.startPct;
      uvt_pkg::ADR_BLOCK: next_dat[uvt_pkg::PCT_W-1:0] = cfg.blockPct;
      uvt_pkg::ADR_HYST:  next_dat[uvt_pkg::PCT_W-1:0] = cfg.hystPct;
      uvt_pkg::ADR_DELAY: next_dat[uvt_pkg::DELAY_W-1:0] = cfg.delayMs;
      uvt_pkg::ADR_STAT: begin
        next_dat[uvt_pkg::NUM_PH-1:0]  = startOut;
        next_dat[uvt_pkg::ST_GEN_START] = generalStart;
        next_dat[uvt_pkg::ST_GEN_TRIP]  = generalTrip;
        next_dat[uvt_pkg::ST_BLOCKED]   = functionBlockInput;
      end
      uvt_pkg::ADR_IRQ:   next_dat[uvt_pkg::IRQ_W-1:0] = irqStatus;
      uvt_pkg::ADR_MASK:  next_dat[uvt_pkg::IRQ_W-1:0] = irqMask;
      uvt_pkg::ADR_V1:    next_dat[uvt_pkg::VOLT_W-1:0] = volt[0];
      uvt_pkg::ADR_V2:    next_dat[uvt_pkg::VOLT_W-1:0] = volt[1];
      uvt_pkg::ADR_V3:    next_dat[uvt_pkg::VOLT_W-1:0] = volt[2];
      uvt_pkg::ADR_TRCNT: next_dat[uvt_pkg::CNT_W-1:0] = tripEvents;
      default:            next_dat = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dat_o <= '0;
    end else if (access && !we_i) begin
      dat_o <= next_dat;
    end
  end

endmodule : uvt_undervoltage_function

// File: uvt_undervoltage_function_checker.sv
/*
  Port checker of the undervoltage trip block.
  Assumes a bind from the bench top that hands on TICK_CYCLES.
*/
module uvt_undervoltage_function_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic                       ref_clk,
  input wire logic                       reset,
  input wire logic                       cyc_i,
  input wire logic                       stb_i,
  input wire logic [uvt_pkg::DAT_W-1:0]  dat_o,
  input wire logic                       ack_o,
  input wire logic [uvt_pkg::VOLT_W-1:0] phase1Fundamental,
  input wire logic                       functionBlockInput,
  input wire logic                       phase1Start,
  input wire logic                       phase2Start,
  input wire logic                       phase3Start,
  input wire logic                       generalStart,
  input wire logic                       generalTrip
);
  timeunit 1ns;
  timeprecision 1ps;
  // shortest delay, less one tick of granularity and the pipeline
  localparam int MIN_RUN = (50 - 1) * TICK_CYCLES - 2;
  logic [15:0] startRun;
  always_ff @(posedge ref_clk) begin
    if (reset || !generalStart) begin
      startRun <= 16'h0000;
    end else if (startRun != 16'hFFFF) begin
      startRun <= startRun + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_quiet;
    !phase1Start && !phase2Start && !phase3Start && !generalStart
      && !generalTrip;
  endsequence
  a_ack_follows_req: assert property (s_req |=> ack_o)
    else $error("no ack after a request");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  a_read_data_hold: assert property ($changed(dat_o) |-> ack_o)
    else $error("read data moved outside an answer");
  a_block_quiets_all: assert property (functionBlockInput |=> s_quiet)
    else $error("output active one cycle after block input");
  a_gen_start_any: assert property (generalStart ==
      (phase1Start || phase2Start || phase3Start))
    else $error("general start differs from phase starts");
  a_trip_with_start: assert property (generalTrip |-> generalStart)
    else $error("trip without start");
  a_start_below_max: assert property ($rose(phase1Start) |->
      $past(phase1Fundamental, 2) < 16'h32C8)
    else $error("phase start above the highest threshold");
  a_trip_after_delay: assert property ($rose(generalTrip) |->
      startRun >= MIN_RUN)
    else $error("trip before the shortest delay");
endmodule : uvt_undervoltage_function_checker

// File: uvt_measure_partner.sv
/*
  Far-side model: the measurement stage and the user equation that drives
  the block input. Assumes the bench sets the requests on ref_clk.
*/
module uvt_measure_partner (
  input  wire logic [2:0][15:0] reqV,
  input  wire logic             ref_clk,
  input  wire logic             reqBlk,
  output logic      [15:0]      phase1Fundamental = 16'h2710,
  output logic      [15:0]      phase2Fundamental = 16'h2710,
  output logic      [15:0]      phase3Fundamental = 16'h2710,
  output logic                  functionBlockInput = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // phase or pair magnitudes share one format, so both pass the same way
  always @(posedge ref_clk) begin
    phase1Fundamental <= reqV[0];
    phase2Fundamental <= reqV[1];
    phase3Fundamental <= reqV[2];
    functionBlockInput <= reqBlk;
  end
endmodule : uvt_measure_partner

// File: uvt_undervoltage_function_tb.sv
/*
  Self-checking bench of the undervoltage trip block: defaults, clamps,
  voting, hysteresis, block level, block input, start-only and interrupt.
  Assumes TICK_CYCLES cut to 4 clocks, so a millisecond is 4 cycles.
*/
bind uvt_undervoltage_function uvt_undervoltage_function_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) chk (
  .ref_clk(ref_clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .phase1Fundamental(phase1Fundamental),
  .functionBlockInput(functionBlockInput), .phase1Start(phase1Start),
  .phase2Start(phase2Start), .phase3Start(phase3Start),
  .generalStart(generalStart), .generalTrip(generalTrip)
);
module uvt_undervoltage_function_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  localparam int DL   = 50;
  logic             ref_clk, reset, cyc, stb, we, ack, reqBlk, blkIn;
  logic             p1, p2, p3, gS, gT, irq;
  logic [7:0]       adr;
  logic [31:0]      wdat, datO, rdat;
  logic [2:0][15:0] reqV;
  logic [15:0]      v1, v2, v3;
  logic [2:0]       masks[3] = '{3'h1, 3'h3, 3'h7};
  logic [7:0]       defAdr[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  logic [31:0]      defVal[5] = '{32'h0, 32'h5A, 32'h0A, 32'h05, 32'h64};
  int               fails, compares, cycles, seed, oper, lowCnt, trips;
  int               vv[3];
  int               hv[$] = '{8000, 9200, 9600, 500, 1500};
  int               he[$] = '{1, 1, 0, 0, 1};

  uvt_measure_partner partner (.reqV(reqV), .ref_clk(ref_clk),
    .reqBlk(reqBlk), .phase1Fundamental(v1), .phase2Fundamental(v2),
    .phase3Fundamental(v3), .functionBlockInput(blkIn));
  uvt_undervoltage_function #(.TICK_CYCLES(TICK)) DUT (
    .ref_clk(ref_clk), .reset(reset), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(datO),
    .ack_o(ack), .phase1Fundamental(v1), .phase2Fundamental(v2),
    .phase3Fundamental(v3), .functionBlockInput(blkIn),
    .phase1Start(p1), .phase2Start(p2), .phase3Start(p3),
    .generalStart(gS), .generalTrip(gT), .irq(irq));

  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge ref_clk);
    while (ack !== 1'b1);
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wrd(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    wb(1'b1, a, d);
    wb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask : wrd

  task automatic setv();
    @(posedge ref_clk);
    for (int p = 0; p < 3; p++)
      reqV[p] <= 16'(vv[p]);
    repeat (6) @(posedge ref_clk);
  endtask : setv

  // settings stay at 90 % start and 10 % block, 100 counts a percent
  function automatic logic exStart(int v);
    return oper != 0 && v < 90 * 100 && v >= 10 * 100;
  endfunction : exStart

  task automatic cmpStarts();
    logic [3:0] e;
    e = {exStart(vv[2]), exStart(vv[1]), exStart(vv[0]), 1'b0};
    e[0] = |e[3:1];
    check({28'h0, p3, p2, p1, gS}, {28'h0, e});
  endtask : cmpStarts

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // the whole run needs about 3000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 12000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    seed = 32'h7C83;
    reset = 1'b1;
    {cyc, stb, we, reqBlk, adr, wdat} = '0;
    reqV = {3{16'h2710}};
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, defAdr[i], 32'h0);
      check(rdat, defVal[i]);
    end
    wrd(8'h30, 32'hFFFF, 32'h0);
    wrd(uvt_pkg::ADR_START, 32'hFF, 32'h82);
    wrd(uvt_pkg::ADR_START, 32'h5A, 32'h5A);
    wrd(uvt_pkg::ADR_BLOCK, 32'h30, 32'h14);
    wrd(uvt_pkg::ADR_BLOCK, 32'h0A, 32'h0A);
    wrd(uvt_pkg::ADR_DELAY, 32'h01, 32'h32);
    wrd(uvt_pkg::ADR_HYST, 32'h00, 32'h01);
    wrd(uvt_pkg::ADR_HYST, 32'h05, 32'h05);
    for (int i = 0; i < 12; i++) begin
      oper = i % 4;
      lowCnt = 0;
      wb(1'b1, uvt_pkg::ADR_MASK, {30'h0, {2{i[0]}}});
      wb(1'b1, uvt_pkg::ADR_CTRL, 32'(oper));
      for (int p = 0; p < 3; p++) begin
        vv[p] = masks[i / 4][p] ? 3000 + ({$random(seed)} % 5000) : 10000;
        lowCnt += masks[i / 4][p];
      end
      setv();
      cmpStarts();
      repeat ((DL - 1) * TICK - 8) @(posedge ref_clk);
      check({31'h0, gT}, 32'h0);
      repeat (12) @(posedge ref_clk);
      check({31'h0, gT}, 32'(oper != 0 && lowCnt >= oper));
      trips += int'(oper != 0 && lowCnt >= oper);
      check({31'h0, irq}, 32'(i[0] && oper != 0));
      wb(1'b1, uvt_pkg::ADR_IRQ, 32'h3);
      repeat (2) @(posedge ref_clk);
      check({31'h0, irq}, 32'h0);
      vv = '{10000, 10000, 10000};
      setv();
      cmpStarts();
    end
    oper = 1;
    wb(1'b1, uvt_pkg::ADR_CTRL, 32'h1);
    foreach (hv[k]) begin
      vv = '{hv[k], 10000, 10000};
      setv();
      check({31'h0, p1}, 32'(he[k]));
    end
    @(posedge ref_clk);
    reqBlk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check({27'h0, p1, p2, p3, gS, gT}, 32'h0);
    reqBlk <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check({31'h0, p1}, 32'h1);
    wb(1'b1, uvt_pkg::ADR_CTRL, 32'h5);
    repeat ((DL + 3) * TICK + 8) @(posedge ref_clk);
    check({30'h0, gS, gT}, 32'h2);
    wb(1'b1, uvt_pkg::ADR_CTRL, 32'h1);
    repeat (4) @(posedge ref_clk);
    check({30'h0, gS, gT}, 32'h3);
    trips++;
    wb(1'b0, uvt_pkg::ADR_TRCNT, 32'h0);
    check(rdat, 32'(trips));
    tally_and_finish();
  end
endmodule : uvt_undervoltage_function_tb
